// ==== common/cell_select_pkg.sv ====
// Package with register map, field layout and carrier types for the data 3/4 input selector
//Operation
//- Bits 7 and 3 of the selection register read zero; writes to them are dropped.
//- Data-four field bits 6..4: codes 111..100 pick cell inputs 3..0.
//- Data-four field codes 011..000 pick cell inputs 15..12.
//- Data-three field bits 2..0: codes 111..100 pick cell inputs 15..12.
//- Each selected line goes to the gates both true and inverted, per-gate enabled.
package cell_select_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int IN_COUNT = 16;
	localparam int GATE_COUNT = 4;
	localparam int SEL_W = 3;
	localparam int IDX_W = 4;
	localparam logic [ADDR_W-1:0] SELECT_OFFSET = 4'h0;
	localparam logic [ADDR_W-1:0] ENABLE_OFFSET = 4'h4;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
	localparam int D4_LSB = 4;
	localparam int D3_LSB = 0;
	localparam logic [7:0] SELECT_IMPL_MASK = 8'h77;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [IDX_W-1:0] D4_BASE = 4'hc;
	localparam logic [IDX_W-1:0] D3_BASE = 4'h8;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [DATA_W-1:0] writedata;
		logic [3:0] byteenable;
	} bus_req_s;

	typedef struct packed {
		logic data_four_true_form;
		logic data_four_inverted_form;
		logic data_three_true_form;
		logic data_three_inverted_form;
	} data_forms_s;
endpackage : cell_select_pkg

// ==== rtl/source_mux.sv ====
// One eight-to-one source selector over a sixteen-input bus with a code-to-index base offset
`timescale 1ns/1ps
`default_nettype none
module source_mux #(
	parameter int N = 16,
	parameter logic [3:0] BASE = 4'h0
) (
	// Selection
	input wire logic [2:0] code_i,
	input wire logic [N-1:0] cell_input_bus_i,
	// Result
	output logic line_o
);
	import cell_select_pkg::*;
	// Index is base plus the code, wrapping modulo sixteen
	wire [3:0] index = 4'(BASE + {1'b0, code_i});
	assign line_o = cell_input_bus_i[index];
endmodule : source_mux
`default_nettype wire

// ==== rtl/gate_enable.sv ====
// Per-gate enable of the true and inverted forms of data lines three and four
`timescale 1ns/1ps
`default_nettype none
module gate_enable (
	// Forms and enables
	input wire cell_select_pkg::data_forms_s forms_i,
	input wire logic [3:0] enable_i,
	// Gated terms
	output logic [3:0] terms_o
);
	import cell_select_pkg::*;
	assign terms_o = enable_i & forms_i;
endmodule : gate_enable
`default_nettype wire

// ==== rtl/logic_cell_data34_input_select.sv ====
// Data 3/4 input selector with Avalon-MM register access
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module logic_cell_data34_input_select (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Avalon-MM slave
	input wire logic [cell_select_pkg::ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [cell_select_pkg::DATA_W-1:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [cell_select_pkg::DATA_W-1:0] readdata_o,
	output logic waitrequest_o,
	// Cell inputs
	input wire logic [cell_select_pkg::IN_COUNT-1:0] cell_input_bus_i,
	// Data lines and gate terms
	output logic cell_data_line_three_o,
	output logic cell_data_line_four_o,
	output cell_select_pkg::data_forms_s forms_o,
	output logic [cell_select_pkg::GATE_COUNT*4-1:0] gate_terms_o
);
	import cell_select_pkg::*;

	logic [7:0] data_three_four_source_select;
	logic [GATE_COUNT*4-1:0] gate_enables;
	logic answered;
	wire bus_req_s req = '{address_i, read_i, write_i, writedata_i, byteenable_i};
	wire access = (req.read | req.write) & ~answered;
	// Second cycle of a request: waitrequest is low, so writes land here
	wire done = (req.read | req.write) & answered;
	wire sel_hit = req.address == SELECT_OFFSET;
	wire en_hit = req.address == ENABLE_OFFSET;
	wire st_hit = req.address == STATUS_OFFSET;
	wire [2:0] data_four_source_field = data_three_four_source_select[D4_LSB +: SEL_W];
	wire [2:0] data_three_source_field = data_three_four_source_select[D3_LSB +: SEL_W];
	wire line_four;
	wire line_three;

	// One wait cycle, answer on the second edge
	assign waitrequest_o = (read_i | write_i) & ~answered;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			answered <= 1'b0;
		end else begin
			answered <= access;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			data_three_four_source_select <= SELECT_RESET;
		end else if (req.write && done && sel_hit && req.byteenable[0]) begin
			data_three_four_source_select <= req.writedata[7:0] & SELECT_IMPL_MASK;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			gate_enables <= '0;
		end else if (req.write && done && en_hit) begin
			if (req.byteenable[0]) begin
				gate_enables[7:0] <= req.writedata[7:0];
			end
			if (req.byteenable[1]) begin
				gate_enables[15:8] <= req.writedata[15:8];
			end
		end
	end

	wire [DATA_W-1:0] read_mux = sel_hit ? {24'h000000, data_three_four_source_select} :
		en_hit ? {16'h0000, gate_enables} :
		st_hit ? {12'h000, cell_input_bus_i, 2'h0, cell_data_line_four_o, cell_data_line_three_o} :
		UNMAPPED_READ;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			readdata_o <= '0;
		end else if (req.read && access) begin
			readdata_o <= read_mux;
		end
	end

	// Data four: base 12 gives 000->12..011->15, 100->0..111->3
	source_mux #(.N(IN_COUNT), .BASE(D4_BASE)) mux_four (
		.code_i(data_four_source_field),
		.cell_input_bus_i(cell_input_bus_i),
		.line_o(line_four)
	);
	// Data three: base 8 gives 000->8..111->15
	source_mux #(.N(IN_COUNT), .BASE(D3_BASE)) mux_three (
		.code_i(data_three_source_field),
		.cell_input_bus_i(cell_input_bus_i),
		.line_o(line_three)
	);

	assign cell_data_line_four_o = line_four;
	assign cell_data_line_three_o = line_three;
	assign forms_o = '{line_four, ~line_four, line_three, ~line_three};

	genvar g;
	generate
		for (g = 0; g < GATE_COUNT; g++) begin : gates
			gate_enable u_en (
				.forms_i(forms_o),
				.enable_i(gate_enables[g*4 +: 4]),
				.terms_o(gate_terms_o[g*4 +: 4])
			);
		end
	endgenerate
endmodule : logic_cell_data34_input_select
`default_nettype wire

// ==== verif/cell_source_model.sv ====
// Random cell input sources for the selector
`timescale 1ns/1ps
`default_nettype none
module cell_source_model (
	input wire logic mclk_i,
	output logic [15:0] cell_input_bus_o = 16'h0000
);
	int seed = 32'h7f523e61;
	always @(posedge mclk_i) cell_input_bus_o <= 16'($random(seed));
endmodule : cell_source_model
`default_nettype wire

// ==== verif/sel_checker_assertions.sv ====
// Assertions for the data 3/4 selector
`timescale 1ns/1ps
`default_nettype none
module sel_checker import cell_select_pkg::*; (
	// Bus and lines
	input wire logic mclk_i, nrst_i, read_i, write_i, waitrequest_o, cell_data_line_three_o, cell_data_line_four_o,
	input wire logic [ADDR_W-1:0] address_i,
	input wire logic [DATA_W-1:0] writedata_i, readdata_o,
	input wire logic [IN_COUNT-1:0] cell_input_bus_i,
	input wire data_forms_s forms_o
);
	logic [7:0] sel;
	wire hit = !waitrequest_o && address_i == SELECT_OFFSET;
	always_ff @(posedge mclk_i) sel <= !nrst_i ? 8'h00 : (hit && write_i) ? writedata_i[7:0] & 8'h77 : sel;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	sequence sel_read; read_i && hit; endsequence
	AST_READBACK: assert property (sel_read |-> readdata_o[7:0] == sel) else $error("readback");
	AST_D4_HI: assert property (sel[6] |-> cell_data_line_four_o == cell_input_bus_i[sel[6:4] + 4'hc]) else $error("d4");
	AST_D4_LO: assert property (!sel[6] |-> cell_data_line_four_o == cell_input_bus_i[sel[6:4] + 4'hc]) else $error("d4");
	AST_D3_HI: assert property (sel[2] |-> cell_data_line_three_o == cell_input_bus_i[sel[2:0] + 4'h8]) else $error("d3");
	AST_D3_LO: assert property (!sel[2] |-> cell_data_line_three_o == cell_input_bus_i[sel[2:0] + 4'h8]) else $error("d3");
	sequence req_done; (read_i || write_i) && !waitrequest_o; endsequence
	AST_WAIT_AGAIN: assert property (req_done |=> !(read_i || write_i) || waitrequest_o) else $error("wait");
	AST_FORMS: assert property (forms_o == {cell_data_line_four_o, !cell_data_line_four_o,
		cell_data_line_three_o, !cell_data_line_three_o}) else $error("forms");
endmodule : sel_checker
bind logic_cell_data34_input_select sel_checker u_chk (.*);
`default_nettype wire

// ==== verif/tb_logic_cell_data34_input_select.sv ====
// Bench for the data 3/4 selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_logic_cell_data34_input_select;
	import cell_select_pkg::*;
	logic mclk_i = 0, nrst_i = 0, rd = 0, wr = 0, l3, l4, wt;
	logic [3:0] adr = 0;
	logic [31:0] wd = 0, rdat, exp_rd;
	logic [15:0] bus, gt, en;
	logic [3:0] fm;
	int seed = 32'h7f523e61;
	logic [31:0] q[$];
	int n_fail = 0, check_count = 0, cyc = 0;
	always #10 mclk_i = ~mclk_i;
	cell_source_model SRC (.mclk_i(mclk_i), .cell_input_bus_o(bus));
	logic_cell_data34_input_select DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .address_i(adr), .read_i(rd), .write_i(wr),
		.writedata_i(wd), .byteenable_i(4'hf), .readdata_o(rdat), .waitrequest_o(wt), .cell_input_bus_i(bus),
		.cell_data_line_three_o(l3), .cell_data_line_four_o(l4), .forms_o(fm), .gate_terms_o(gt));
	task automatic give_verdict;
		$display("fails %0d checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic bus_op(input logic w, input logic [3:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge mclk_i); while (wt !== 1'b0);
		wr <= 0;
		rd <= 0;
		@(posedge mclk_i);
	endtask : bus_op
	always @(posedge mclk_i) begin
		if (rd && wt === 1'b0) begin
			exp_rd = q.pop_front();
			`CHK("readdata", exp_rd, rdat)
		end
		if (++cyc == 2000) begin
			n_fail++;
			give_verdict;
		end
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1;
		@(posedge mclk_i);
		q.push_back(0);
		bus_op(0, SELECT_OFFSET, 0);
		for (int c = 0; c < 8; c++) begin
			bus_op(1, SELECT_OFFSET, {24'h0, 1'b1, c[2:0], 1'b1, c[2:0]});
			q.push_back({24'h0, 1'b0, c[2:0], 1'b0, c[2:0]});
			bus_op(0, SELECT_OFFSET, 0);
			repeat (4) begin
				@(negedge mclk_i);
				`CHK("line4", bus[c[2:0] + 4'hc], l4)
				`CHK("line3", bus[c[2:0] + 4'h8], l3)
			end
			@(posedge mclk_i);
		end
		en = 16'($random(seed));
		bus_op(1, ENABLE_OFFSET, {16'h0, en});
		q.push_back({16'h0, en});
		bus_op(0, ENABLE_OFFSET, 0);
		repeat (4) begin
			@(negedge mclk_i);
			`CHK("forms", {l4, !l4, l3, !l3}, fm)
			for (int g = 0; g < 4; g++) `CHK("terms", en[g*4 +: 4] & {l4, !l4, l3, !l3}, gt[g*4 +: 4])
		end
		@(posedge mclk_i);
		q.push_back(0);
		bus_op(0, 4'hc, 0);
		give_verdict;
	end
endmodule : tb_logic_cell_data34_input_select
`default_nettype wire
